/* sdram_link.sv */
interface sdram_link;
  logic ck;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [sdram_mode_pkg::BA_W-1:0] ba;
  logic [sdram_mode_pkg::ADDR_W-1:0] addr;
  logic [sdram_mode_pkg::DQ_W-1:0] ctl_dq_o;
  logic ctl_dq_oe;
  logic [sdram_mode_pkg::DQ_W-1:0] dev_dq_o;
  logic dev_dq_oe;
  logic [sdram_mode_pkg::DQ_W-1:0] dq;
  logic dqs_o;
  logic dqs_oe;
  logic dqs_n_o;
  logic dqs_n_oe;
  logic rdqs_o;
  logic rdqs_oe;
  logic rdqs_n_o;
  logic rdqs_n_oe;

  // Wire level of the shared data lines; an undriven bus reads low
  assign dq = dev_dq_oe ? dev_dq_o : (ctl_dq_oe ? ctl_dq_o : '0);

  modport device (
    input ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr, dq,
    output dev_dq_o, dev_dq_oe, dqs_o, dqs_oe, dqs_n_o, dqs_n_oe, rdqs_o, rdqs_oe, rdqs_n_o, rdqs_n_oe
  );
  modport controller (
    output ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr, ctl_dq_o, ctl_dq_oe,
    input dq, dqs_o, dqs_oe
  );
endinterface : sdram_link

/* sdram_mode_controller.sv */
module sdram_mode_controller #(
  parameter int DIV_HALF = 6,
  parameter int LINK_MHZ = 8
) (
  input wire logic core_clk,
  input wire logic arst_n,
  sdram_link.controller link,
  input wire logic cmd_valid,
  input wire sdram_mode_pkg::cmd_e cmd_code,
  input wire logic [sdram_mode_pkg::BA_W-1:0] cmd_ba,
  input wire logic [sdram_mode_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic cmd_cke,
  input wire logic [sdram_mode_pkg::DQ_W-1:0] wdata,
  output logic cmd_ready,
  output logic [sdram_mode_pkg::DQ_W-1:0] rdata,
  output logic rdata_valid,
  output logic read_blocked,
  output logic calibration_open
);
  logic [7:0] div_cnt;
  logic rise_en;
  logic fall_en;
  logic [sdram_mode_pkg::DQ_W-1:0] dq_s;
  logic [2:0] rl_shadow;
  logic dll_off;
  logic relock_due;
  logic row_shadow;
  logic pre_pending;
  logic [3:0] gap_cnt;
  logic [7:0] lock_cnt;
  logic [3:0] rd_wait;
  logic [3:0] rd_beats;
  logic [3:0] wr_wait;
  logic [3:0] wr_beats;
  logic busy;
  logic allowed;
  logic is_lm_main;
  logic [sdram_mode_pkg::ADDR_W-1:0] addr_out;

  // Link clock divider; rising and falling enables mark the link edges
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt <= '0;
      link.ck <= 1'b0;
    end else if (div_cnt == 8'(DIV_HALF - 1)) begin
      div_cnt <= '0;
      link.ck <= ~link.ck;
    end else begin
      div_cnt <= div_cnt + 8'h1;
    end
  end
  assign rise_en = div_cnt == 8'(DIV_HALF - 1) && !link.ck;
  assign fall_en = div_cnt == 8'(DIV_HALF - 1) && link.ck;

  sdram_sync #(.W(sdram_mode_pkg::DQ_W)) u_dq_sync (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .d(link.dq),
    .q(dq_s)
  );

  // A load may not meet an open row or a burst in flight
  assign busy = rd_wait != 4'h0 || rd_beats != 4'h0 || wr_wait != 4'h0 || wr_beats != 4'h0;
  assign read_blocked = lock_cnt != 8'h0;
  assign is_lm_main = cmd_code == sdram_mode_pkg::CMD_LOAD_MODE && cmd_ba == sdram_mode_pkg::BA_MAIN;
  always_comb begin
    allowed = gap_cnt == 4'h0 && !pre_pending;
    if (cmd_code == sdram_mode_pkg::CMD_READ && read_blocked) begin
      allowed = 1'b0;
    end
    if (cmd_code == sdram_mode_pkg::CMD_LOAD_MODE && (row_shadow || busy)) begin
      allowed = 1'b0;
    end
  end
  assign cmd_ready = fall_en && cmd_valid && allowed;

  // Main register loads are cleaned before they reach the pins
  always_comb begin
    addr_out = cmd_addr;
    if (is_lm_main) begin
      addr_out[sdram_mode_pkg::TEST_BIT] = 1'b0;
      if (cmd_addr[sdram_mode_pkg::RL_LSB +: 3] < sdram_mode_pkg::RL_MIN) begin
        addr_out[sdram_mode_pkg::RL_LSB +: 3] = sdram_mode_pkg::RL_MIN;
      end
      if (cmd_addr[sdram_mode_pkg::WR_LSB +: 3] < sdram_mode_pkg::WR_CODE_MIN) begin
        addr_out[sdram_mode_pkg::WR_LSB +: 3] = sdram_mode_pkg::WR_CODE_MIN;
      end
      if (relock_due) begin
        addr_out[sdram_mode_pkg::RELOCK_BIT] = 1'b1;
      end
    end
  end

  // Command pins change on the falling link edge so the device samples them mid-cycle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      link.cke <= 1'b0;
      {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= sdram_mode_pkg::CMD_NOP;
      link.ba <= '0;
      link.addr <= '0;
    end else if (fall_en) begin
      link.cke <= cmd_cke;
      link.ba <= cmd_ba;
      link.addr <= pre_pending ? {sdram_mode_pkg::ADDR_W{1'b1}} : addr_out;
      if (pre_pending) begin
        {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= sdram_mode_pkg::CMD_PRECHARGE;
      end else if (cmd_ready) begin
        {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= cmd_code;
      end else begin
        {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= sdram_mode_pkg::CMD_NOP;
      end
    end
  end

  // Shadow of what the device was told, and the waits that follow from it
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rl_shadow <= sdram_mode_pkg::RL_RESET;
      dll_off <= 1'b0;
      relock_due <= 1'b0;
      calibration_open <= 1'b0;
      row_shadow <= 1'b0;
      pre_pending <= 1'b0;
      gap_cnt <= '0;
    end else if (fall_en) begin
      pre_pending <= cmd_ready && cmd_code == sdram_mode_pkg::CMD_REFRESH && dll_off && LINK_MHZ < sdram_mode_pkg::SLOW_LINK_MHZ;
      if (pre_pending) begin
        row_shadow <= 1'b0;
      end else if (cmd_ready) begin
        case (cmd_code)
          sdram_mode_pkg::CMD_LOAD_MODE: begin
            gap_cnt <= sdram_mode_pkg::MODE_SET_CLKS;
            if (is_lm_main) begin
              rl_shadow <= addr_out[sdram_mode_pkg::RL_LSB +: 3];
              relock_due <= 1'b0;
            end else if (cmd_ba == sdram_mode_pkg::BA_EXT) begin
              dll_off <= cmd_addr[sdram_mode_pkg::DLL_DIS_BIT];
              relock_due <= !cmd_addr[sdram_mode_pkg::DLL_DIS_BIT];
              calibration_open <= cmd_addr[sdram_mode_pkg::CAL_LSB +: 3] != 3'h0;
            end
          end
          sdram_mode_pkg::CMD_ACTIVATE: row_shadow <= 1'b1;
          sdram_mode_pkg::CMD_PRECHARGE: row_shadow <= 1'b0;
          sdram_mode_pkg::CMD_WRITE: row_shadow <= !cmd_addr[sdram_mode_pkg::AUTO_PRE_BIT];
          default: row_shadow <= row_shadow;
        endcase
      end else if (gap_cnt != 4'h0) begin
        gap_cnt <= gap_cnt - 4'h1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      lock_cnt <= '0;
    end else if (cmd_ready && is_lm_main && addr_out[sdram_mode_pkg::RELOCK_BIT]) begin
      lock_cnt <= sdram_mode_pkg::DLL_LOCK_CLKS;
    end else if (rise_en && lock_cnt != 8'h0) begin
      lock_cnt <= lock_cnt - 8'h1;
    end
  end

  // Read capture at mid-cycle after latency; write drive from the falling edge before each beat
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_wait <= '0;
      rd_beats <= '0;
      wr_wait <= '0;
      wr_beats <= '0;
      rdata <= '0;
      rdata_valid <= 1'b0;
    end else begin
      rdata_valid <= 1'b0;
      if (cmd_ready && cmd_code == sdram_mode_pkg::CMD_READ) begin
        rd_wait <= {1'b0, rl_shadow} + 4'h1;
      end else if (rise_en && rd_wait != 4'h0) begin
        rd_wait <= rd_wait - 4'h1;
      end
      if (rise_en && rd_wait == 4'h1) begin
        rd_beats <= sdram_mode_pkg::BURST_LEN;
      end else if (fall_en && rd_beats != 4'h0) begin
        rd_beats <= rd_beats - 4'h1;
        rdata <= dq_s;
        rdata_valid <= 1'b1;
      end
      if (cmd_ready && cmd_code == sdram_mode_pkg::CMD_WRITE) begin
        wr_wait <= {1'b0, rl_shadow} - 4'h1;
      end else if (fall_en && wr_wait != 4'h0) begin
        wr_wait <= wr_wait - 4'h1;
      end
      if (fall_en && wr_wait == 4'h1) begin
        wr_beats <= sdram_mode_pkg::BURST_LEN;
      end else if (fall_en && wr_beats != 4'h0) begin
        wr_beats <= wr_beats - 4'h1;
      end
    end
  end

  // Write data held in a flop; one word repeated over the burst
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      link.ctl_dq_o <= '0;
    end else if (cmd_ready && cmd_code == sdram_mode_pkg::CMD_WRITE) begin
      link.ctl_dq_o <= wdata;
    end
  end
  assign link.ctl_dq_oe = wr_beats != 4'h0;
endmodule : sdram_mode_controller

/* sdram_mode_device.sv */
module sdram_mode_device (
  input wire logic core_clk,
  input wire logic arst_n,
  sdram_link.device link,
  output logic test_mode,
  output logic [2:0] read_latency,
  output logic [3:0] write_recovery,
  output logic powerdown_slow_exit,
  output logic dll_running,
  output logic dll_reset_pulse,
  output logic drive_reduced,
  output logic [2:0] driver_calibration,
  output logic self_refresh,
  output logic active_power_down,
  output logic precharge_power_down,
  output logic exit_busy,
  output logic row_open
);
  localparam int SW = 1 + 1 + 4 + sdram_mode_pkg::BA_W + sdram_mode_pkg::ADDR_W + sdram_mode_pkg::DQ_W;

  logic [SW-1:0] pins_s;
  logic ck_s;
  logic cke_s;
  logic [3:0] cmd_bits;
  logic [sdram_mode_pkg::BA_W-1:0] ba_s;
  logic [sdram_mode_pkg::ADDR_W-1:0] addr_s;
  logic [sdram_mode_pkg::DQ_W-1:0] dq_s;
  logic ck_d;
  logic edge_en;
  sdram_mode_pkg::cmd_e cmd;
  logic lm_main;
  logic lm_ext;
  logic dll_relock_bit;
  logic dll_disable_bit;
  logic strobe_complement_disable_bit;
  logic read_strobe_copy_enable_bit;
  logic output_disable_bit;
  logic [2:0] wr_code;
  logic [3:0] rd_wait;
  logic [3:0] rd_beats;
  logic [3:0] wr_wait;
  logic [3:0] wr_beats;
  logic wr_auto_pre;
  logic [3:0] rec_cnt;
  logic [3:0] exit_cnt;
  logic [sdram_mode_pkg::DQ_W-1:0] stored_word;
  logic strobe_q;

  // Every link pin crosses two flops; the link clock is only sampled, never used as a clock
  sdram_sync #(.W(SW)) u_pin_sync (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .d({link.ck, link.cke, link.cs_n, link.ras_n, link.cas_n, link.we_n, link.ba, link.addr, link.dq}),
    .q(pins_s)
  );
  assign {ck_s, cke_s, cmd_bits, ba_s, addr_s, dq_s} = pins_s;
  assign cmd = sdram_mode_pkg::cmd_e'(cmd_bits);

  // Rising link edge found in the core domain
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ck_d <= 1'b0;
    end else begin
      ck_d <= ck_s;
    end
  end
  assign edge_en = ck_s & ~ck_d;

  assign lm_main = edge_en && cke_s && cmd == sdram_mode_pkg::CMD_LOAD_MODE && ba_s == sdram_mode_pkg::BA_MAIN;
  assign lm_ext = edge_en && cke_s && cmd == sdram_mode_pkg::CMD_LOAD_MODE && ba_s == sdram_mode_pkg::BA_EXT;

  // Main mode register; a test-mode load leaves every other field as it was
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      test_mode <= 1'b0;
      read_latency <= sdram_mode_pkg::RL_RESET;
      wr_code <= sdram_mode_pkg::WR_CODE_RESET;
      powerdown_slow_exit <= 1'b0;
    end else if (lm_main) begin
      test_mode <= addr_s[sdram_mode_pkg::TEST_BIT];
      if (!addr_s[sdram_mode_pkg::TEST_BIT]) begin
        read_latency <= addr_s[sdram_mode_pkg::RL_LSB +: 3];
        wr_code <= addr_s[sdram_mode_pkg::WR_LSB +: 3];
        powerdown_slow_exit <= addr_s[sdram_mode_pkg::PDX_BIT];
      end
    end
  end
  assign write_recovery = sdram_mode_pkg::wr_clocks(wr_code);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      dll_relock_bit <= 1'b0;
    end else if (lm_main && !addr_s[sdram_mode_pkg::TEST_BIT] && addr_s[sdram_mode_pkg::RELOCK_BIT]) begin
      dll_relock_bit <= 1'b1; // A new request wins over the clear
    end else if (edge_en) begin
      dll_relock_bit <= 1'b0;
    end
  end

  // Extended mode register
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      dll_disable_bit <= 1'b0;
      drive_reduced <= 1'b0;
      driver_calibration <= sdram_mode_pkg::CAL_RESET;
      strobe_complement_disable_bit <= 1'b0;
      read_strobe_copy_enable_bit <= 1'b0;
      output_disable_bit <= 1'b0;
    end else if (lm_ext) begin
      dll_disable_bit <= addr_s[sdram_mode_pkg::DLL_DIS_BIT];
      drive_reduced <= addr_s[sdram_mode_pkg::DRIVE_BIT];
      driver_calibration <= addr_s[sdram_mode_pkg::CAL_LSB +: 3];
      strobe_complement_disable_bit <= addr_s[sdram_mode_pkg::COMP_DIS_BIT];
      read_strobe_copy_enable_bit <= addr_s[sdram_mode_pkg::RDQS_BIT];
      output_disable_bit <= addr_s[sdram_mode_pkg::OUT_DIS_BIT];
    end
  end

  // Power states follow the clock enable; exit timing depends on the state left
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      self_refresh <= 1'b0;
      active_power_down <= 1'b0;
      precharge_power_down <= 1'b0;
      exit_cnt <= '0;
    end else if (edge_en) begin
      if (!cke_s) begin
        if (!self_refresh && !active_power_down && !precharge_power_down) begin
          self_refresh <= cmd == sdram_mode_pkg::CMD_REFRESH && !row_open;
          active_power_down <= cmd != sdram_mode_pkg::CMD_REFRESH && row_open;
          precharge_power_down <= cmd != sdram_mode_pkg::CMD_REFRESH && !row_open;
        end
      end else begin
        self_refresh <= 1'b0;
        active_power_down <= 1'b0;
        precharge_power_down <= 1'b0;
        if (active_power_down) begin
          exit_cnt <= powerdown_slow_exit ? sdram_mode_pkg::SLOW_EXIT_CLKS : sdram_mode_pkg::FAST_EXIT_CLKS;
        end else if (precharge_power_down || self_refresh) begin
          exit_cnt <= sdram_mode_pkg::FAST_EXIT_CLKS;
        end else if (exit_cnt != 4'h0) begin
          exit_cnt <= exit_cnt - 4'h1;
        end
      end
    end
  end
  assign exit_busy = exit_cnt != 4'h0;

  assign dll_running = !dll_disable_bit && !self_refresh && !(active_power_down && powerdown_slow_exit);

  // DLL reset request, from the relock bit or from leaving self refresh
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      dll_reset_pulse <= 1'b0;
    end else begin
      dll_reset_pulse <= edge_en && (dll_relock_bit || (self_refresh && cke_s));
    end
  end

  // Read pipeline: latency count, then a fixed burst
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_wait <= '0;
      rd_beats <= '0;
    end else if (edge_en) begin
      if (cke_s && cmd == sdram_mode_pkg::CMD_READ) begin
        rd_wait <= {1'b0, read_latency};
      end else if (rd_wait != 4'h0) begin
        rd_wait <= rd_wait - 4'h1;
      end
      if (rd_wait == 4'h1) begin
        rd_beats <= sdram_mode_pkg::BURST_LEN;
      end else if (rd_beats != 4'h0) begin
        rd_beats <= rd_beats - 4'h1;
      end
    end
  end

  // Write pipeline: capture at write latency, then recovery before the internal precharge
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_wait <= '0;
      wr_beats <= '0;
      wr_auto_pre <= 1'b0;
      rec_cnt <= '0;
      stored_word <= '0;
    end else if (edge_en) begin
      if (cke_s && cmd == sdram_mode_pkg::CMD_WRITE) begin
        wr_wait <= {1'b0, read_latency} - 4'h1;
        wr_auto_pre <= addr_s[sdram_mode_pkg::AUTO_PRE_BIT];
      end else if (wr_wait != 4'h0) begin
        wr_wait <= wr_wait - 4'h1;
      end
      if (wr_wait == 4'h1) begin
        stored_word <= dq_s;
        wr_beats <= sdram_mode_pkg::BURST_LEN - 4'h1;
      end else if (wr_beats != 4'h0) begin
        stored_word <= dq_s;
        wr_beats <= wr_beats - 4'h1;
      end
      if (wr_beats == 4'h1 && wr_auto_pre) begin
        rec_cnt <= write_recovery;
      end else if (rec_cnt != 4'h0) begin
        rec_cnt <= rec_cnt - 4'h1;
      end
    end
  end

  // Open row tracking; the internal precharge lands when recovery runs out
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      row_open <= 1'b0;
    end else if (edge_en && cke_s && cmd == sdram_mode_pkg::CMD_ACTIVATE) begin
      row_open <= 1'b1;
    end else if (edge_en && ((cke_s && cmd == sdram_mode_pkg::CMD_PRECHARGE) || rec_cnt == 4'h1)) begin
      row_open <= 1'b0;
    end
  end

  // Output data and strobe level are registered
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      link.dev_dq_o <= '0;
      strobe_q <= 1'b0;
    end else begin
      link.dev_dq_o <= stored_word;
      strobe_q <= ck_s;
    end
  end

  assign link.dev_dq_oe = rd_beats != 4'h0 && !output_disable_bit;
  assign link.dqs_o = strobe_q;
  assign link.dqs_oe = link.dev_dq_oe;
  assign link.dqs_n_o = ~strobe_q;
  assign link.dqs_n_oe = link.dqs_oe && !strobe_complement_disable_bit;
  assign link.rdqs_o = strobe_q;
  assign link.rdqs_oe = link.dqs_oe && read_strobe_copy_enable_bit;
  assign link.rdqs_n_o = ~strobe_q;
  assign link.rdqs_n_oe = link.rdqs_oe && !strobe_complement_disable_bit;
endmodule : sdram_mode_device

/* sdram_mode_pkg.sv */
package sdram_mode_pkg;
  // Link widths
  localparam int ADDR_W = 14;
  localparam int BA_W = 3;
  localparam int DQ_W = 8;
  // Command encoding on {select, row strobe, column strobe, write enable}, all active low
  typedef enum logic [3:0] {
    CMD_LOAD_MODE = 4'b0000,
    CMD_REFRESH = 4'b0001,
    CMD_PRECHARGE = 4'b0010,
    CMD_ACTIVATE = 4'b0011,
    CMD_WRITE = 4'b0100,
    CMD_READ = 4'b0101,
    CMD_NOP = 4'b0111
  } cmd_e;
  // Register select on the bank lines of a load-mode command
  localparam logic [2:0] BA_MAIN = 3'h0;
  localparam logic [2:0] BA_EXT = 3'h1;
  // Main mode register fields
  localparam int RL_LSB = 4;
  localparam int TEST_BIT = 7;
  localparam int RELOCK_BIT = 8;
  localparam int WR_LSB = 9;
  localparam int PDX_BIT = 12;
  // Column address bit that requests auto precharge
  localparam int AUTO_PRE_BIT = 10;
  // Extended mode register fields
  localparam int DLL_DIS_BIT = 0;
  localparam int DRIVE_BIT = 1;
  localparam int CAL_LSB = 7;
  localparam int COMP_DIS_BIT = 10;
  localparam int RDQS_BIT = 11;
  localparam int OUT_DIS_BIT = 12;
  // Legal latency range in link clocks, and legal recovery code range
  localparam logic [2:0] RL_MIN = 3'h3;
  localparam logic [2:0] RL_MAX = 3'h7;
  localparam logic [2:0] WR_CODE_MIN = 3'h1;
  localparam logic [2:0] WR_CODE_MAX = 3'h7;
  // Power-up values of the decoded fields
  localparam logic [2:0] RL_RESET = 3'h3;
  localparam logic [2:0] WR_CODE_RESET = 3'h1;
  localparam logic [2:0] CAL_RESET = 3'h0;
  // Sequence timing, in link clocks; slow link threshold in MHz
  localparam logic [3:0] BURST_LEN = 4'h4;
  localparam logic [7:0] DLL_LOCK_CLKS = 8'hc8;
  localparam logic [3:0] MODE_SET_CLKS = 4'h2;
  localparam logic [3:0] FAST_EXIT_CLKS = 4'h2;
  localparam logic [3:0] SLOW_EXIT_CLKS = 4'h7;
  localparam int SLOW_LINK_MHZ = 25;

  // Recovery code 1..7 means 2..8 clocks
  function automatic logic [3:0] wr_clocks(input logic [2:0] code);
    wr_clocks = {1'b0, code} + 4'h1;
  endfunction : wr_clocks
endpackage : sdram_mode_pkg

/* sdram_mode_props.sv */
module sdram_mode_props (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic ck,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [2:0] ba,
  input wire logic [13:0] addr,
  input wire logic dev_dq_oe,
  input wire logic dqs_oe,
  input wire logic dqs_n_oe,
  input wire logic rdqs_oe,
  input wire logic rdqs_n_oe
);
  logic ck_q;
  logic [2:0] ext;
  logic [1:0] gap;
  logic [7:0] lock;
  logic [3:0] cmd;
  logic rise;
  logic mld;
  // Commands count only at a link rising edge, where the pins are settled
  assign rise = ck & ~ck_q;
  assign cmd = rise ? {cs_n, ras_n, cas_n, we_n} : 4'hf;
  assign mld = cmd == 4'h0 && ba == 3'h0;
  // Shadow leads the device by a few cycles, harmless while the bus is idle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ck_q <= 1'b0;
      ext <= 3'h0;
      gap <= 2'h2;
      lock <= 8'h00;
    end else begin
      ck_q <= ck;
      if (cmd == 4'h0 && ba == 3'h1) ext <= addr[12:10];
      if (cmd == 4'h0) gap <= 2'h0;
      else if (rise && gap != 2'h2) gap <= gap + 2'h1;
      if (mld && addr[8]) lock <= 8'hc7;
      else if (rise && lock != 8'h00) lock <= lock - 8'h01;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  AST_TEST_OFF: assert property (mld |-> !addr[7]) else $error("test bit");
  AST_WR_CODE: assert property (mld |-> addr[11:9] != 3'h0) else $error("recovery code");
  AST_LOAD_GAP: assert property (cmd < 4'h7 |-> gap != 2'h0) else $error("load spacing");
  AST_RELOCK_WAIT: assert property (cmd == 4'h5 |-> lock == 8'h00) else $error("early read");
  AST_OUT_OFF: assert property (ext[2] |-> !(dev_dq_oe || dqs_oe || dqs_n_oe || rdqs_oe || rdqs_n_oe))
    else $error("output on");
  AST_COMP_OFF: assert property (ext[0] |-> !dqs_n_oe) else $error("inverse strobe");
  AST_RDQS_N: assert property (rdqs_n_oe |-> ext[1] && !ext[0]) else $error("inverse read strobe");
  AST_RDQS_SAME: assert property (rdqs_oe == (dqs_oe && ext[1])) else $error("read strobe");
endmodule : sdram_mode_props

/* sdram_sync.sv */
module sdram_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // Two stages; only the second stage is visible to logic
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : sdram_sync

/* testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_cke = 1'b1;
  logic [3:0] code = 4'h7;
  logic [2:0] cmd_ba = 3'h0;
  logic [13:0] cmd_addr = 14'h0000;
  logic [7:0] wdata = 8'h00;
  logic [13:0] ext_values[3] = '{14'h0800, 14'h0400, 14'h1000};
  logic cmd_ready, rdata_valid, blocked, cal_open, test_mode, slow, dll_running, pulse, drive, self_refresh, apd, ppd, xbusy;
  logic [7:0] rdata;
  logic [2:0] latency, cal;
  logic [3:0] recovery;
  int mismatches, check_count, cycles, pulses, n, busy_cycles, pre_all;
  sdram_link link_if ();
  sdram_mode_controller i_sdram_mode_controller (.core_clk(core_clk), .arst_n(arst_n), .link(link_if),
    .cmd_valid(cmd_valid), .cmd_code(sdram_mode_pkg::cmd_e'(code)), .cmd_ba(cmd_ba), .cmd_addr(cmd_addr),
    .cmd_cke(cmd_cke), .wdata(wdata), .cmd_ready(cmd_ready), .rdata(rdata), .rdata_valid(rdata_valid),
    .read_blocked(blocked), .calibration_open(cal_open));
  sdram_mode_device i_sdram_mode_device (.core_clk(core_clk), .arst_n(arst_n), .link(link_if), .test_mode(test_mode),
    .read_latency(latency), .write_recovery(recovery), .powerdown_slow_exit(slow), .dll_running(dll_running),
    .dll_reset_pulse(pulse), .drive_reduced(drive), .driver_calibration(cal), .self_refresh(self_refresh),
    .active_power_down(apd), .precharge_power_down(ppd), .exit_busy(xbusy), .row_open());
  sdram_mode_props i_props (.core_clk(core_clk), .arst_n(arst_n), .ck(link_if.ck), .cs_n(link_if.cs_n),
    .ras_n(link_if.ras_n), .cas_n(link_if.cas_n), .we_n(link_if.we_n), .ba(link_if.ba), .addr(link_if.addr),
    .dev_dq_oe(link_if.dev_dq_oe), .dqs_oe(link_if.dqs_oe), .dqs_n_oe(link_if.dqs_n_oe),
    .rdqs_oe(link_if.rdqs_oe), .rdqs_n_oe(link_if.rdqs_n_oe));
  task automatic end_of_test();
    if (mismatches == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Request stays up until taken at a falling link edge
  task automatic send(input logic [3:0] c, input logic [13:0] a = 14'h0, input logic [2:0] b = 3'h0,
                      input logic k = 1'b1);
    code <= c;
    cmd_addr <= a;
    cmd_ba <= b;
    cmd_cke <= k;
    cmd_valid <= 1'b1;
    do @(negedge core_clk); while (cmd_ready !== 1'b1);
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    @(posedge core_clk);
  endtask : send
  // A trailing command lets the load settle in the device
  task automatic ld(input logic [2:0] b, input logic [13:0] a);
    send(4'h0, a, b);
    send(4'h7);
  endtask : ld
  // First beat is about latency plus one link cycles of 12 clocks away
  task automatic rd(input int lat, input logic [7:0] exp);
    send(4'h5);
    n = 0;
    while (rdata_valid !== 1'b1) begin
      @(negedge core_clk);
      n++;
    end
    chk("latency_clocks", 16'(lat + 1), 16'((n + 6) / 12));
    chk("rdata", {8'h00, exp}, {8'h00, rdata});
    repeat (48) @(posedge core_clk);
    send(4'h2, 14'h0400);
  endtask : rd
  // Power-down round trip; exit time is measured as core cycles with exit_busy high
  task automatic pd(input logic act, input logic exp_dll, input int exp_busy);
    int base;
    base = busy_cycles;
    if (act) send(4'h3);
    send(4'h7, 14'h0, 3'h0, 1'b0);
    send(4'h7, 14'h0, 3'h0, 1'b0);
    chk("active_pd", 16'(act), 16'(apd));
    chk("precharge_pd", 16'(!act), 16'(ppd));
    chk("dll_pd", 16'(exp_dll), 16'(dll_running));
    send(4'h7);
    repeat (96) @(posedge core_clk);
    chk("exit_cycles", 16'(exp_busy), 16'(busy_cycles - base));
    if (act) send(4'h2, 14'h0400);
  endtask : pd
  // Clock at 100 MHz
  initial forever #5 core_clk = ~core_clk;
  // Hang ceiling, DLL reset pulse count, exit busy cycles and precharge-all cycles
  always @(posedge core_clk) begin
    cycles++;
    if (pulse === 1'b1) pulses++;
    if (xbusy === 1'b1) busy_cycles++;
    // Inserted precharge-all carries an all-ones address; ordinary precharges here do not
    if ({link_if.cs_n, link_if.ras_n, link_if.cas_n, link_if.we_n} === 4'h2 && link_if.addr === 14'h3fff) pre_all++;
    if (cycles == 40000) begin
      mismatches++;
      end_of_test();
    end
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    chk("latency", 16'h3, 16'(latency));
    ld(3'h1, 14'h0382);
    chk("drive", 16'h1, 16'(drive));
    chk("cal", 16'h7, 16'(cal));
    chk("cal_open", 16'h1, 16'(cal_open));
    ld(3'h1, 14'h0000);
    chk("cal_open", 16'h0, 16'(cal_open));
    ld(3'h0, 14'h1fd2);
    chk("test", 16'h0, 16'(test_mode));
    chk("latency", 16'h5, 16'(latency));
    chk("recovery", 16'h8, 16'(recovery));
    chk("slow", 16'h1, 16'(slow));
    chk("pulses", 16'h1, 16'(pulses));
    chk("blocked", 16'h1, 16'(blocked));
    for (int lat = 3; lat < 8; lat++) begin
      wdata <= 8'(8'h30 + lat);
      ld(3'h0, {5'h01, 2'h0, 3'(lat), 4'h2});
      chk("latency", 16'(lat), 16'(latency));
      send(4'h3);
      send(4'h4);
      repeat (48) @(posedge core_clk);
      rd(lat, 8'(8'h30 + lat));
    end
    foreach (ext_values[i]) begin
      ld(3'h1, ext_values[i]);
      send(4'h3);
      rd(7, ext_values[i][12] ? 8'h00 : 8'h37);
    end
    // Exit counts span one link cycle of 12 core clocks per exit clock
    pd(1'b1, 1'b1, 12 * sdram_mode_pkg::FAST_EXIT_CLKS);
    ld(3'h0, 14'h1032);
    chk("slow", 16'h1, 16'(slow));
    pd(1'b1, 1'b0, 12 * sdram_mode_pkg::SLOW_EXIT_CLKS);
    pd(1'b0, 1'b1, 12 * sdram_mode_pkg::FAST_EXIT_CLKS);
    send(4'h1, 14'h0, 3'h0, 1'b0);
    send(4'h7, 14'h0, 3'h0, 1'b0);
    chk("self_refresh", 16'h1, 16'(self_refresh));
    chk("dll", 16'h0, 16'(dll_running));
    send(4'h7);
    send(4'h7);
    chk("dll", 16'h1, 16'(dll_running));
    chk("pulses", 16'h3, 16'(pulses));
    ld(3'h1, 14'h0001);
    chk("dll", 16'h0, 16'(dll_running));
    send(4'h1);
    send(4'h7);
    // Precharge-all holds the pins for one link cycle of 12 core clocks
    chk("precharge_all", 16'hc, 16'(pre_all));
    end_of_test();
  end
endmodule : testbench
